// ### src/pdc_top.sv
// Purpose: divider settings and power-down control of a dual synthesizer
// Assumes: serial pins, enable pin and auto power-up are synchronous
// Notes: configuration is write-only; derived values are registered
//
// Overview of operation
// - Reference divider divides by its 6-bit field, 1 to 63.
// - Prescaler select 0 picks 16/17/20/21, 1 picks 32/33/36/37.
// - Main power-down 0 with no override keeps the main loop running.
// - Effective main power-down stops the loop, charge pump floats.
// - Enable pin low powers main loop down above everything else.
// - Enable high plus auto power-up powers the main loop up.
// - Otherwise the main power-down bit decides main loop power.
// - 12-bit denominator field is the low fractional denominator part.
// - Main divide equals modulus times coarse plus four quad plus unit.
// - Aux power-down 1 stops aux loop and floats its charge pump.
// - Main word write with auto power-up clears aux power-down.
`timescale 1ns/10ps
`include "pdc_cfg.svh"
module pdc_top
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // serial write pins
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_latch,
    // power control inputs
    input wire logic chip_enable,
    input wire logic auto_powerup,
    // feedback divider word from the fractional path
    input wire logic [10:0] main_feedback_divider,
    // loop power outputs
    output logic main_pll_enable,
    output logic main_cp_hiz,
    output logic aux_pll_enable,
    output logic aux_cp_hiz,
    // divider settings
    output pdc_pkg::pdc_ps_t main_prescaler_select,
    output logic [5:0] main_ref_divider,
    output logic [11:0] main_frac_denominator,
    output logic [11:0] main_div_value,
    output logic [18:0] aux_feedback_divider,
    output logic ref_div_pulse
);
    import pdc_pkg::*;

    logic rs1_q, rst_sync_b;
    logic word_valid;
    logic [`PDC_WORD_W-1:0] word;
    logic main_wr, aux_wr;

    // release reset through two flops so removal is clean
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rs1_q <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rs1_q <= 1'b1;
            rst_sync_b <= rs1_q;
        end
    end

    pdc_shift u_shift
    (
        .clk(ref_clk),
        .rst_n(rst_sync_b),
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .ser_latch(ser_latch),
        .word_valid(word_valid),
        .word(word)
    );

    // route by the low nibble; other patterns belong to other blocks
    assign main_wr = word_valid &&
        (word[`PDC_ROUTE_HI:`PDC_ROUTE_LO] == `PDC_ROUTE_MAIN);
    assign aux_wr = word_valid &&
        (word[`PDC_ROUTE_HI:`PDC_ROUTE_LO] == `PDC_ROUTE_AUX);

    logic main_pd_q, main_pd_d;
    pdc_ps_t ps_q, ps_d;
    logic [5:0] ref_q, ref_d;
    logic [11:0] fd_q, fd_d;
    logic aux_pd_q, aux_pd_d;
    logic [18:0] aux_n_q, aux_n_d;

    // configuration words; the auto clear lands with the main write
    always_comb
    begin
        main_pd_d = main_pd_q;
        ps_d = ps_q;
        ref_d = ref_q;
        fd_d = fd_q;
        aux_pd_d = aux_pd_q;
        aux_n_d = aux_n_q;
        if (main_wr)
        begin
            main_pd_d = word[`PDC_MAIN_PD_BIT];
            ps_d = pdc_ps_t'(word[`PDC_MAIN_PS_BIT]);
            ref_d = word[`PDC_MAIN_REF_HI:`PDC_MAIN_REF_LO];
            fd_d = word[`PDC_MAIN_FD_HI:`PDC_MAIN_FD_LO];
            if (auto_powerup)
            begin
                aux_pd_d = 1'b0;
            end
        end
        if (aux_wr)
        begin
            aux_pd_d = word[`PDC_AUX_PD_BIT];
            aux_n_d = word[`PDC_AUX_N_HI:`PDC_AUX_N_LO];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            main_pd_q <= `PDC_RST_MAIN_PD;
            ps_q <= pdc_ps_t'(`PDC_RST_PS);
            ref_q <= `PDC_RST_REF;
            fd_q <= `PDC_RST_FD;
            aux_pd_q <= `PDC_RST_AUX_PD;
            aux_n_q <= `PDC_RST_AUX_N;
        end
        else
        begin
            main_pd_q <= main_pd_d;
            ps_q <= ps_d;
            ref_q <= ref_d;
            fd_q <= fd_d;
            aux_pd_q <= aux_pd_d;
            aux_n_q <= aux_n_d;
        end
    end

    assign main_prescaler_select = ps_q;
    assign main_ref_divider = ref_q;
    assign main_frac_denominator = fd_q;
    assign aux_feedback_divider = aux_n_q;

    pdc_pwr_t pwr_d;
    logic men_q, men_d, aen_q, aen_d;

    // precedence: enable pin, then auto power-up, then the bit
    always_comb
    begin
        if (!chip_enable)
        begin
            pwr_d = PDC_PWR_OFF;
        end
        else if (auto_powerup)
        begin
            pwr_d = PDC_PWR_AUTO;
        end
        else if (main_pd_q)
        begin
            pwr_d = PDC_PWR_OFF;
        end
        else
        begin
            pwr_d = PDC_PWR_ON;
        end
        case (pwr_d)
            PDC_PWR_AUTO: men_d = 1'b1;
            PDC_PWR_ON: men_d = 1'b1;
            default: men_d = 1'b0;
        endcase
        aen_d = chip_enable && !aux_pd_q;
    end

    // hiz is the inverse of enable, kept as its own flop for a clean pin
    always_ff @(posedge ref_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            main_pll_enable <= 1'b0;
            main_cp_hiz <= 1'b1;
            aux_pll_enable <= 1'b0;
            aux_cp_hiz <= 1'b1;
        end
        else
        begin
            main_pll_enable <= men_d;
            main_cp_hiz <= !men_d;
            aux_pll_enable <= aen_d;
            aux_cp_hiz <= !aen_d;
        end
    end

    logic [5:0] rcnt_q, rcnt_d;
    logic rpulse_d;
    logic [11:0] modulus, div_d;

    // reference divider; a zero field is treated like one, never stalls
    always_comb
    begin
        modulus = (ps_q == PDC_PS_LARGE) ? `PDC_MOD_LARGE : `PDC_MOD_SMALL;
        div_d = 12'(modulus *
            {6'h00, main_feedback_divider[`PDC_FB_COARSE_HI:`PDC_FB_COARSE_LO]})
            + {7'h00, main_feedback_divider[`PDC_FB_QUAD_HI:`PDC_FB_QUAD_LO],
            2'h0}
            + {10'h000, main_feedback_divider[`PDC_FB_UNIT_HI:`PDC_FB_UNIT_LO]};
        rcnt_d = rcnt_q + 6'h01;
        rpulse_d = 1'b0;
        if ((ref_q <= 6'h01) || (rcnt_q >= ref_q - 6'h01))
        begin
            rcnt_d = 6'h00;
            rpulse_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            rcnt_q <= 6'h00;
            ref_div_pulse <= 1'b0;
            main_div_value <= 12'h000;
        end
        else
        begin
            rcnt_q <= rcnt_d;
            ref_div_pulse <= rpulse_d;
            main_div_value <= div_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_b);

    sequence seq_main_wr;
        main_wr;
    endsequence

    sequence seq_gap2;
        !ref_div_pulse ##1 ref_div_pulse;
    endsequence

    AST_MAIN_LOAD: assert property (seq_main_wr |=>
        main_ref_divider == $past(word[21:16]) &&
        main_frac_denominator == $past(word[15:4]))
        else $error("main word not loaded");
    AST_AUX_LOAD: assert property (aux_wr |=>
        aux_feedback_divider == $past(word[22:4]))
        else $error("aux word not loaded");
    AST_CE_LOW: assert property (!chip_enable |=>
        !main_pll_enable && main_cp_hiz && !aux_pll_enable)
        else $error("enable pin low did not power down");
    AST_AUTO_UP: assert property (chip_enable && auto_powerup |=>
        main_pll_enable && !main_cp_hiz)
        else $error("auto power-up ignored");
    AST_PD_OFF: assert property
        (chip_enable && !auto_powerup && main_pd_q |=> main_cp_hiz &&
        !main_pll_enable)
        else $error("power-down bit ignored");
    AST_PD_RUN: assert property
        (chip_enable && !auto_powerup && !main_pd_q |=> main_pll_enable)
        else $error("main loop not running");
    AST_AUX_CLEAR: assert property
        (seq_main_wr ##0 auto_powerup && !aux_wr |=> !aux_pd_q)
        else $error("aux power-down not cleared");
    AST_AUX_PD: assert property (chip_enable && aux_pd_q |=>
        aux_cp_hiz && !aux_pll_enable)
        else $error("aux power-down ignored");
    AST_DIV_VALUE: assert property ($past(ps_q) == PDC_PS_LARGE &&
        $stable(main_feedback_divider) |-> main_div_value ==
        12'(32 * main_feedback_divider[10:5] +
        4 * main_feedback_divider[4:2] + main_feedback_divider[1:0]))
        else $error("divide value wrong");
    AST_REF_DIV2: assert property (ref_div_pulse && ref_q == 6'h02 &&
        $stable(ref_q) ##0 !main_wr[*1] |=> seq_gap2)
        else $error("reference divide by two wrong");
    AST_REF_DIV1: assert property (ref_q == 6'h01 && $stable(ref_q)
        |=> ref_div_pulse)
        else $error("reference divide by one wrong");
endmodule

// ### src/pdc_cfg.svh
// Purpose: constants for the divider and power-down configuration block
// Assumes: serial words are 24 bits, routing bits in the low nibble
// Notes: reset values are the safe, powered-down choice
`ifndef PDC_CFG_SVH
`define PDC_CFG_SVH

`define PDC_WORD_W 24
`define PDC_ROUTE_HI 3
`define PDC_ROUTE_LO 0
`define PDC_ROUTE_MAIN 4'h3
`define PDC_ROUTE_AUX 4'h5

// main divider configuration word fields
`define PDC_MAIN_PD_BIT 23
`define PDC_MAIN_PS_BIT 22
`define PDC_MAIN_REF_HI 21
`define PDC_MAIN_REF_LO 16
`define PDC_MAIN_FD_HI 15
`define PDC_MAIN_FD_LO 4

// auxiliary divider configuration word fields
`define PDC_AUX_PD_BIT 23
`define PDC_AUX_N_HI 22
`define PDC_AUX_N_LO 4

// feedback divider value fields
`define PDC_FB_COARSE_HI 10
`define PDC_FB_COARSE_LO 5
`define PDC_FB_QUAD_HI 4
`define PDC_FB_QUAD_LO 2
`define PDC_FB_UNIT_HI 1
`define PDC_FB_UNIT_LO 0
`define PDC_MOD_SMALL 12'h010
`define PDC_MOD_LARGE 12'h020

// reset values
`define PDC_RST_MAIN_PD 1'b1
`define PDC_RST_AUX_PD 1'b1
`define PDC_RST_PS 1'b0
`define PDC_RST_REF 6'h01
`define PDC_RST_FD 12'h000
`define PDC_RST_AUX_N 19'h00000

`endif

// ### src/pdc_pkg.sv
// Purpose: types for the divider and power-down configuration block
// Assumes: constants live in pdc_cfg.svh
// Notes: none
package pdc_pkg;
    typedef enum logic [1:0] {
        PDC_PWR_OFF = 2'b00,
        PDC_PWR_AUTO = 2'b01,
        PDC_PWR_ON = 2'b10
    } pdc_pwr_t;

    typedef enum logic {
        PDC_PS_SMALL = 1'b0,
        PDC_PS_LARGE = 1'b1
    } pdc_ps_t;
endpackage

// ### src/pdc_shift.sv
// Purpose: serial receiver, three wires, shifts msb first, latches a word
// Assumes: serial pins are synchronous to the clock and slower than it
// Notes: one bit per serial clock rising edge
`timescale 1ns/10ps
`include "pdc_cfg.svh"
module pdc_shift
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial pins
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_latch,
    // received word
    output logic word_valid,
    output logic [`PDC_WORD_W-1:0] word
);
    import pdc_pkg::*;

    logic sclk_q, sclk_d;
    logic le_q, le_d;
    logic [`PDC_WORD_W-1:0] sh_q, sh_d;
    logic valid_q, valid_d;
    logic [`PDC_WORD_W-1:0] word_q, word_d;

    // shift on serial clock rise, publish on latch rise
    always_comb
    begin
        sclk_d = ser_clk;
        le_d = ser_latch;
        sh_d = sh_q;
        valid_d = 1'b0;
        word_d = word_q;
        if (ser_clk && !sclk_q)
        begin
            sh_d = {sh_q[`PDC_WORD_W-2:0], ser_data};
        end
        if (ser_latch && !le_q)
        begin
            valid_d = 1'b1;
            word_d = sh_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q <= 1'b0;
            le_q <= 1'b0;
            sh_q <= '0;
            valid_q <= 1'b0;
            word_q <= '0;
        end
        else
        begin
            sclk_q <= sclk_d;
            le_q <= le_d;
            sh_q <= sh_d;
            valid_q <= valid_d;
            word_q <= word_d;
        end
    end

    assign word_valid = valid_q;
    assign word = word_q;
endmodule

// ### tb/pdc_host.sv
// Purpose: host model that writes configuration words on the serial pins
// Assumes: one bit every two ref_clk cycles, msb first
// Notes: data line shows the inverted last bit once a frame ends
`timescale 1ns/10ps
module pdc_host
(
    // clock
    input wire logic clk,
    // serial pins
    output logic ser_clk,
    output logic ser_data,
    output logic ser_latch
);
    initial
    begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_latch = 1'b0;
    end

    // clock low with data, then high; the rise is seen one edge later
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--)
        begin
            @(posedge clk);
            ser_clk <= 1'b0;
            ser_data <= w[i];
            @(posedge clk);
            ser_clk <= 1'b1;
        end
        // clock rests low so no rise shares the latch cycle
        @(posedge clk);
        ser_clk <= 1'b0;
        ser_data <= ~w[0];
        @(posedge clk);
        ser_latch <= 1'b1;
        @(posedge clk);
        ser_latch <= 1'b0;
    endtask

    // main divider word, routed by the low nibble
    task automatic write_main(input logic pd, input logic ps,
        input logic [5:0] rd, input logic [11:0] fd);
        send({pd, ps, rd, fd, 4'h3});
    endtask

    // aux divider word, routed by the low nibble
    task automatic write_aux(input logic pd, input logic [18:0] n);
        send({pd, n, 4'h5});
    endtask
endmodule

// ### tb/tb.sv
// Purpose: self-checking bench for the divider and power-down block
// Assumes: host model drives the serial pins
// Notes: waits are fixed counts from the hand-over latencies
`timescale 1ns/10ps
module tb;
    import pdc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic chip_enable = 1'b1;
    logic auto_powerup = 1'b0;
    logic [10:0] main_feedback_divider = 11'h000;
    logic ser_clk, ser_data, ser_latch;
    logic main_pll_enable, main_cp_hiz, aux_pll_enable, aux_cp_hiz;
    pdc_ps_t main_prescaler_select;
    logic [5:0] main_ref_divider;
    logic [11:0] main_frac_denominator, main_div_value;
    logic [18:0] aux_feedback_divider;
    logic ref_div_pulse;
    logic e;
    int err_total = 0;
    int num_checks = 0;
    int cnt;
    int rtab[4] = '{1, 2, 5, 63};

    always #20 ref_clk = ~ref_clk;

    pdc_host u_pdc_host (.clk(ref_clk), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_latch(ser_latch));

    pdc_top u_pdc_top (.ref_clk(ref_clk), .rst_b(rst_b),
        .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch),
        .chip_enable(chip_enable), .auto_powerup(auto_powerup),
        .main_feedback_divider(main_feedback_divider),
        .main_pll_enable(main_pll_enable), .main_cp_hiz(main_cp_hiz),
        .aux_pll_enable(aux_pll_enable), .aux_cp_hiz(aux_cp_hiz),
        .main_prescaler_select(main_prescaler_select),
        .main_ref_divider(main_ref_divider),
        .main_frac_denominator(main_frac_denominator),
        .main_div_value(main_div_value),
        .aux_feedback_divider(aux_feedback_divider),
        .ref_div_pulse(ref_div_pulse));

    // value compare, four-state exact
    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // pulse count compare
    task automatic chk_cnt(input int got, input int exp);
        num_checks++;
        if (got != exp)
        begin
            err_total++;
            $display("[FAIL] %0t count %0d exp %0d", $time, got, exp);
        end
    endtask

    // fields land two edges after the latch, power one edge later
    task automatic settle();
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // cuts a hang short; the run needs far less
    initial
    begin
        #3ms;
        err_total++;
        report_and_stop();
    end

    initial
    begin
        repeat (3) @(posedge ref_clk);
        #1;
        chk({main_pll_enable, main_cp_hiz, aux_pll_enable, aux_cp_hiz},
            4'h5);
        chk(main_ref_divider, 6'h01);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        settle();
        chk({main_pll_enable, main_cp_hiz}, 2'b01);
        $display("test reset done");

        // large prescaler, top of the legal main divide range
        // large prescaler paired here with the largest reference field, 63
        u_pdc_host.write_main(1'b0, 1'b1, 6'h3F, 12'hABC);
        main_feedback_divider <= 11'h7FD;
        settle();
        chk(main_prescaler_select, 1'b1);
        chk(main_ref_divider, 6'h3F);
        chk(main_frac_denominator, 12'hABC);
        chk({main_pll_enable, main_cp_hiz}, 2'b10);
        chk(main_div_value, 12'h7FD);
        @(posedge ref_clk);
        main_feedback_divider <= 11'h061;
        settle();
        chk(main_div_value, 12'h061);
        u_pdc_host.write_main(1'b0, 1'b0, 6'h01, 12'h001);
        main_feedback_divider <= 11'h7FD;
        settle();
        chk(main_prescaler_select, 1'b0);
        chk(main_div_value, 12'h40D);
        $display("test dividers done");

        // pulse spacing follows the reference field
        foreach (rtab[k])
        begin
            u_pdc_host.write_main(1'b0, 1'b0, rtab[k][5:0], 12'h000);
            repeat (70) @(posedge ref_clk);
            cnt = 0;
            repeat (4 * rtab[k])
            begin
                @(posedge ref_clk);
                #1;
                if (ref_div_pulse === 1'b1)
                    cnt++;
            end
            chk_cnt(cnt, 4);
        end
        $display("test reference done");

        // unrouted words leave every field alone
        u_pdc_host.send({2'b01, 6'h2A, 12'h555, 4'h7});
        u_pdc_host.send({2'b01, 6'h15, 12'h333, 4'h0});
        settle();
        chk(main_ref_divider, 6'h3F);
        chk(main_frac_denominator, 12'h000);
        chk(main_prescaler_select, 1'b0);
        chk(aux_feedback_divider, 19'd0);
        $display("test routing done");

        // enable pin over auto power-up over the power-down bit
        for (int pd = 0; pd < 2; pd++)
        begin
            u_pdc_host.write_main(pd[0], 1'b0, 6'h01, 12'h000);
            for (int i = 0; i < 4; i++)
            begin
                @(posedge ref_clk);
                chip_enable <= i[1];
                auto_powerup <= i[0];
                repeat (3) @(posedge ref_clk);
                #1;
                e = i[1] & (i[0] | ~pd[0]);
                chk({main_pll_enable, main_cp_hiz}, {e, ~e});
            end
        end
        $display("test power done");

        // aux power-down, auto power-up clearing it, enable pin
        @(posedge ref_clk);
        chip_enable <= 1'b1;
        auto_powerup <= 1'b0;
        u_pdc_host.write_aux(1'b1, 19'd24);
        settle();
        chk(aux_feedback_divider, 19'd24);
        chk({aux_pll_enable, aux_cp_hiz}, 2'b01);
        u_pdc_host.write_aux(1'b0, 19'd262143);
        settle();
        chk(aux_feedback_divider, 19'd262143);
        chk({aux_pll_enable, aux_cp_hiz}, 2'b10);
        u_pdc_host.write_aux(1'b1, 19'd524287);
        u_pdc_host.write_main(1'b1, 1'b0, 6'h01, 12'h000);
        settle();
        chk({aux_pll_enable, aux_cp_hiz}, 2'b01);
        chk(aux_feedback_divider, 19'd524287);
        auto_powerup <= 1'b1;
        u_pdc_host.write_main(1'b1, 1'b0, 6'h01, 12'h000);
        settle();
        chk({aux_pll_enable, aux_cp_hiz}, 2'b10);
        chk({main_pll_enable, main_cp_hiz}, 2'b10);
        @(posedge ref_clk);
        chip_enable <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk({aux_pll_enable, aux_cp_hiz}, 2'b01);
        $display("test aux done");
        report_and_stop();
    end
endmodule
